/* dv/cmf_fabric_test.sv */
// Self-checking testbench for the core memory bus fabric
`timescale 1ns/1ps
module cmf_fabric_test;
	logic clk, rst, prd, pwr, srd, pm_rd, pm_wr, db_rd, egot;
	logic [20:0] paddr, pm_addr;
	logic [23:0] saddr, db_addr;
	logic [15:0] prog_q, sec_q, pm_wd, pm_q, db_q, df_q, pb_q;
	logic [31:0] pri_q, da_q;
	cmf_pkg::cmf_xreq_t pri, da;
	cmf_pkg::cmf_wreq_t df, pb;
	cmf_pkg::cmf_erase_t er;
	int fail_count = 0;
	int comparisons = 0;
	int cycles = 0;

	cmf_fabric u_cmf_fabric (.i_ref_clk(clk), .i_rst(rst), .i_prog_rd(prd), .i_prog_wr(pwr),
		.i_prog_addr(paddr), .o_prog_rdata(prog_q), .i_primary(pri), .o_primary_rdata(pri_q),
		.i_secondary_rd(srd), .i_secondary_data_address(saddr), .o_secondary_read_data(sec_q),
		.o_pmem_rd(pm_rd), .o_pmem_wr(pm_wr), .o_pmem_addr(pm_addr), .o_pmem_wdata(pm_wd),
		.i_pmem_rdata(pm_q), .o_dram_a(da), .i_dram_a_rdata(da_q), .o_dram_b_rd(db_rd),
		.o_dram_b_addr(db_addr), .i_dram_b_rdata(db_q), .o_dflash(df), .i_dflash_rdata(df_q),
		.o_peripheral_register_bus(pb), .i_peripheral_register_bus_rdata(pb_q),
		.o_erase_go(egot), .o_erase(er));
	cmf_mem_model u_cmf_mem_model (.i_ref_clk(clk), .i_pmem_rd(pm_rd), .i_pmem_addr(pm_addr),
		.o_pmem_rdata(pm_q), .i_dram_a(da), .o_dram_a_rdata(da_q), .i_dram_b_rd(db_rd),
		.i_dram_b_addr(db_addr), .o_dram_b_rdata(db_q), .i_dflash(df), .o_dflash_rdata(df_q),
		.i_periph(pb), .o_periph_rdata(pb_q));

	// ==========================================================
	// Clock, timeout and helpers
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			fail_count++;
			print_verdict();
		end
	end
	task automatic go;
		@(posedge clk);
	endtask : go
	task automatic idle;
		prd <= 1'b0;
		pwr <= 1'b0;
		srd <= 1'b0;
		pri <= '0;
	endtask : idle
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : print_verdict

	// ==========================================================
	// Scenarios
	task automatic t_prog;
		go;
		prd <= 1'b1;
		paddr <= 21'h1f0123;
		go;
		prd <= 1'b0;
		pwr <= 1'b1;
		pri <= {2'b00, cmf_pkg::SZ_LONG, 24'h0, 32'habcd1234};
		#1 chk("prog rdata", 32'h0123 ^ 32'h5a5a, prog_q);
		chk("pmem wdata", 32'h1234, pm_wd);
		chk("pmem wr", 32'h1, pm_wr);
		go;
		idle();
		$display("test prog done");
	endtask : t_prog
	task automatic t_dual;
		go;
		pri <= {2'b10, cmf_pkg::SZ_LONG, 24'h000200, 32'h0};
		srd <= 1'b1;
		saddr <= 24'h000300;
		go;
		idle();
		#1 chk("primary rdata", 32'h1311_7577, pri_q);
		chk("secondary rdata", 32'h2122, sec_q);
		go;
		#1 chk("primary hold", 32'h1311_7577, pri_q);
		$display("test dual done");
	endtask : t_dual
	task automatic t_byte;
		go;
		pri <= {2'b01, cmf_pkg::SZ_BYTE, 24'h800100, 32'h5a};
		#1 chk("byte msb", 32'h000100, da.addr);
		chk("byte wr", 32'h1, da.wr);
		go;
		pri <= {2'b01, cmf_pkg::SZ_WORD, 24'h800100, 32'h5a};
		#1 chk("word msb", 32'h800100, da.addr);
		go;
		pri <= {2'b10, cmf_pkg::SZ_BYTE, 24'h800100, 32'h0};
		#1 chk("byte rd msb", 32'h000100, da.addr);
		go;
		idle();
		#1 chk("byte rdata", {16'h0100 ^ 16'h1111, 16'h0100 ^ 16'h7777}, pri_q);
		$display("test byte done");
	endtask : t_byte
	task automatic t_periph;
		go;
		pri <= {2'b10, cmf_pkg::SZ_WORD, 24'h00f010, 32'h0};
		#1 chk("periph rd", 32'h1, pb.rd);
		chk("dram gated", 32'h0, da.rd);
		go;
		pri <= {2'b01, cmf_pkg::SZ_WORD, 24'h00f010, 32'hdead0042};
		#1 chk("periph rdata", 32'hb454, pri_q);
		chk("periph wdata", 32'h0042, pb.wdata);
		chk("periph wr", 32'h1, pb.wr);
		go;
		pri <= {2'b10, cmf_pkg::SZ_WORD, 24'h004020, 32'h0};
		#1 chk("dflash rd", 32'h1, df.rd);
		go;
		idle();
		#1 chk("dflash rdata", 32'h7313, pri_q);
		$display("test periph done");
	endtask : t_periph
	task automatic t_flash;
		go;
		pri <= {2'b01, cmf_pkg::SZ_WORD, 24'h004044, 32'hbeef5678};
		#1 chk("dflash wr", 32'h1, df.wr);
		chk("dflash wdata", 32'h5678, df.wdata);
		chk("dram wr gated", 32'h0, da.wr);
		go;
		pri <= '0;
		srd <= 1'b1;
		saddr <= 24'h004088;
		#1 chk("dflash sec rd", 32'h1, df.rd);
		chk("dflash sec addr", 32'h004088, df.addr);
		go;
		srd <= 1'b0;
		#1 chk("sec flash rdata", 32'h4088 ^ 32'h3333, sec_q);
		$display("test flash done");
	endtask : t_flash
	task automatic t_erase;
		for (int i = 0; i < 3; i++) begin
			go;
			pri <= {2'b01, cmf_pkg::SZ_WORD, cmf_pkg::FLASHCTL_BASE, 32'h3};
			go;
			pri <= {2'b01, cmf_pkg::SZ_WORD, cmf_pkg::FLASHCTL_BASE + 24'h1, 29'h0, i[1:0], i == 2};
			#1 chk("ctl not forwarded", 32'h0, pb.wr);
			go;
			idle();
			#1 chk("erase go", 32'h1, egot);
			chk("erase arr", i, er.arr);
			chk("erase bulk", i == 2, er.bulk);
			if (i == 0) chk("page base", 3 * cmf_pkg::PFLASH_PAGE_WORDS, er.page_base);
			if (i == 1) chk("page base", 3 * cmf_pkg::BDFLASH_PAGE_WORDS, er.page_base);
			if (i == 2) chk("page base", 3 * cmf_pkg::BDFLASH_PAGE_WORDS, er.page_base);
			go;
			#1 chk("erase pulse", 32'h0, egot);
		end
		$display("test erase done");
	endtask : t_erase

	// ==========================================================
	// Main sequence
	initial begin
		rst = 1'b1;
		prd = 1'b0;
		pwr = 1'b0;
		srd = 1'b0;
		paddr = '0;
		saddr = '0;
		pri = '0;
		repeat (12) go;
		rst <= 1'b0;
		t_prog();
		t_dual();
		t_byte();
		t_periph();
		t_flash();
		t_erase();
		print_verdict();
	end
endmodule : cmf_fabric_test

/* dv/cmf_mem_model.sv */
// Memory, flash and peripheral model answering the fabric one cycle after each request
`timescale 1ns/1ps
module cmf_mem_model (
	// Clock
	input wire logic i_ref_clk,
	// Program memory port
	input wire logic i_pmem_rd,
	input wire logic [20:0] i_pmem_addr,
	output logic [15:0] o_pmem_rdata,
	// Data RAM ports
	input wire cmf_pkg::cmf_xreq_t i_dram_a,
	output logic [31:0] o_dram_a_rdata,
	input wire logic i_dram_b_rd,
	input wire logic [23:0] i_dram_b_addr,
	output logic [15:0] o_dram_b_rdata,
	// Data flash and peripheral bus
	input wire cmf_pkg::cmf_wreq_t i_dflash,
	output logic [15:0] o_dflash_rdata,
	input wire cmf_pkg::cmf_wreq_t i_periph,
	output logic [15:0] o_periph_rdata
);
	// ==========================================================
	// Read answers
	// Idle ports invert their last value so stale data never passes for a fresh answer
	initial begin
		o_pmem_rdata = 16'h0;
		o_dram_a_rdata = 32'h0;
		o_dram_b_rdata = 16'h0;
		o_dflash_rdata = 16'h0;
		o_periph_rdata = 16'h0;
	end
	always @(posedge i_ref_clk) begin
		o_pmem_rdata <= i_pmem_rd ? i_pmem_addr[15:0] ^ 16'h5a5a : ~o_pmem_rdata;
		o_dram_a_rdata <= i_dram_a.rd ? {i_dram_a.addr[15:0] ^ 16'h1111,
			i_dram_a.addr[15:0] ^ 16'h7777} : ~o_dram_a_rdata;
		o_dram_b_rdata <= i_dram_b_rd ? i_dram_b_addr[15:0] ^ 16'h2222 : ~o_dram_b_rdata;
		o_dflash_rdata <= i_dflash.rd ? i_dflash.addr[15:0] ^ 16'h3333 : ~o_dflash_rdata;
		o_periph_rdata <= i_periph.rd ? i_periph.addr[15:0] ^ 16'h4444 : ~o_periph_rdata;
	end
endmodule : cmf_mem_model

/* src/cmf_fabric.sv */
// Memory-side bus fabric routing program, primary and secondary data buses
`timescale 1ns/1ps
module cmf_fabric (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// Program bus from the core
	input wire logic i_prog_rd,
	input wire logic i_prog_wr,
	input wire logic [20:0] i_prog_addr,
	output logic [15:0] o_prog_rdata,
	// Primary data bus from the core
	input wire cmf_pkg::cmf_xreq_t i_primary,
	output logic [31:0] o_primary_rdata,
	// Secondary data bus from the core
	input wire logic i_secondary_rd,
	input wire logic [23:0] i_secondary_data_address,
	output logic [15:0] o_secondary_read_data,
	// Program memory port (RAM and flash array share it)
	output logic o_pmem_rd,
	output logic o_pmem_wr,
	output logic [20:0] o_pmem_addr,
	output logic [15:0] o_pmem_wdata,
	input wire logic [15:0] i_pmem_rdata,
	// Data RAM: 32-bit primary port, 16-bit secondary port
	output cmf_pkg::cmf_xreq_t o_dram_a,
	input wire logic [31:0] i_dram_a_rdata,
	output logic o_dram_b_rd,
	output logic [23:0] o_dram_b_addr,
	input wire logic [15:0] i_dram_b_rdata,
	// Data flash array, direct 16-bit word port
	output cmf_pkg::cmf_wreq_t o_dflash,
	input wire logic [15:0] i_dflash_rdata,
	// Peripheral register bus, 16 bits, no wait states
	output cmf_pkg::cmf_wreq_t o_peripheral_register_bus,
	input wire logic [15:0] i_peripheral_register_bus_rdata,
	// Flash module erase command
	output logic o_erase_go,
	output cmf_pkg::cmf_erase_t o_erase
);
	// ==========================================================
	// Address decode
	function automatic logic hit(input logic [23:0] a, input logic [23:0] base,
		input logic [23:0] mask);
		hit = (a & mask) == base;
	endfunction : hit

	typedef enum logic [2:0] {
		TGT_RAM = 3'b001,
		TGT_FLASH = 3'b010,
		TGT_PERIPH = 3'b100
	} cmf_tgt_t;

	logic [23:0] x_addr;
	logic x_periph, x_flashctl, x_dflash, y_dflash;
	cmf_tgt_t tgt_d, tgt_q;
	cmf_tgt_t tgt2_d, tgt2_q;
	logic [31:0] prd_q, prd_d;
	logic [15:0] srd_d;
	logic prd_pend_q, prd_pend_d;

	always_comb begin
		x_addr = i_primary.addr;
		if (i_primary.size == cmf_pkg::SZ_BYTE) begin
			x_addr[cmf_pkg::MSB] = 1'b0;
		end
	end

	// Peripheral and flash windows share the primary address path
	assign x_periph = hit(x_addr, cmf_pkg::PERIPH_BASE, cmf_pkg::PERIPH_MASK);
	assign x_flashctl = hit(x_addr, cmf_pkg::FLASHCTL_BASE, cmf_pkg::FLASHCTL_MASK);
	assign x_dflash = hit(x_addr, cmf_pkg::DFLASH_BASE, cmf_pkg::DFLASH_MASK);
	assign y_dflash = hit(i_secondary_data_address, cmf_pkg::DFLASH_BASE,
		cmf_pkg::DFLASH_MASK);

	// ==========================================================
	// Program path
	assign o_pmem_rd = i_prog_rd;
	assign o_pmem_wr = i_prog_wr;
	assign o_pmem_addr = i_prog_addr;
	assign o_pmem_wdata = i_primary.wdata[15:0];

	// ==========================================================
	// Primary data path
	always_comb begin
		o_dram_a = i_primary;
		o_dram_a.addr = x_addr;
		o_dram_a.rd = i_primary.rd && !x_periph && !x_dflash;
		o_dram_a.wr = i_primary.wr && !x_periph && !x_dflash;
	end

	// Flash array reads and writes bypass the peripheral bus
	always_comb begin
		o_dflash.rd = (i_primary.rd && x_dflash) || (i_secondary_rd && y_dflash);
		o_dflash.wr = i_primary.wr && x_dflash;
		// One shared flash port: a primary access wins over a secondary read
		o_dflash.addr = (i_primary.rd || i_primary.wr) && x_dflash ? x_addr
			: i_secondary_data_address;
		o_dflash.wdata = i_primary.wdata[15:0];
	end

	// Peripheral register bus: same cycle as data memory, low half only
	always_comb begin
		o_peripheral_register_bus.rd = i_primary.rd && x_periph;
		o_peripheral_register_bus.wr = i_primary.wr && x_periph && !x_flashctl;
		o_peripheral_register_bus.addr = x_addr;
		o_peripheral_register_bus.wdata = i_primary.wdata[15:0];
	end

	// ==========================================================
	// Secondary data path: word reads only, simultaneous with primary
	assign o_dram_b_rd = i_secondary_rd && !y_dflash;
	assign o_dram_b_addr = i_secondary_data_address;

	// ==========================================================
	// Read return steering, one cycle after the request
	always_comb begin
		tgt_d = TGT_RAM;
		if (x_periph) begin
			tgt_d = TGT_PERIPH;
		end else if (x_dflash) begin
			tgt_d = TGT_FLASH;
		end
		tgt2_d = y_dflash ? TGT_FLASH : TGT_RAM;
		prd_pend_d = i_primary.rd;
		// Read data is held in prd_q until the next read; in the answer cycle memory data passes straight through
		prd_d = prd_q;
		unique case (tgt_q)
			TGT_RAM: prd_d = i_dram_a_rdata;
			TGT_FLASH: prd_d = {16'h0000, i_dflash_rdata};
			TGT_PERIPH: prd_d = {16'h0000, i_peripheral_register_bus_rdata};
		endcase
		if (!prd_pend_q) begin
			prd_d = prd_q;
		end
		// Secondary and program data are not held: the core takes them in the answer cycle
		srd_d = (tgt2_q == TGT_FLASH) ? i_dflash_rdata : i_dram_b_rdata;
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			tgt_q <= TGT_RAM;
			tgt2_q <= TGT_RAM;
			prd_q <= 32'h00000000;
			prd_pend_q <= 1'b0;
		end else begin
			tgt_q <= tgt_d;
			tgt2_q <= tgt2_d;
			prd_q <= prd_d;
			prd_pend_q <= prd_pend_d;
		end
	end

	// Memories answer one cycle after the address, so data is live then
	assign o_primary_rdata = prd_pend_q ? prd_d : prd_q;
	assign o_secondary_read_data = srd_d;
	assign o_prog_rdata = i_pmem_rdata;

	// ==========================================================
	// Flash control over the peripheral bus
	cmf_flash_ctl u_flash_ctl (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_sel(i_primary.wr && x_flashctl),
		.i_reg(x_addr[5:0]),
		.i_wdata(i_primary.wdata[15:0]),
		.o_erase_go(o_erase_go),
		.o_erase(o_erase)
	);

	// ==========================================================
	// Checks
	a_byte_msb_low: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_primary.size == cmf_pkg::SZ_BYTE && o_dram_a.wr) |-> !o_dram_a.addr[cmf_pkg::MSB])
		else $error("byte access kept address msb");
	a_byte_read_msb: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_primary.size == cmf_pkg::SZ_BYTE && o_dram_a.rd) |-> !o_dram_a.addr[cmf_pkg::MSB])
		else $error("byte read kept address msb");
	a_prog_wdata_low: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		i_prog_wr |-> o_pmem_wdata == i_primary.wdata[15:0])
		else $error("program write data not low half");
	a_prog_addr: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		i_prog_rd |-> (o_pmem_rd && o_pmem_addr == i_prog_addr))
		else $error("program address not forwarded");
	a_periph_decode: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_primary.rd && x_periph) |-> (o_peripheral_register_bus.rd && !o_dram_a.rd))
		else $error("peripheral read not decoded");
	a_periph_zero_wait: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_primary.rd && x_periph) |=>
		o_primary_rdata == {16'h0000, i_peripheral_register_bus_rdata})
		else $error("peripheral read data late or wrong");
	a_periph_upper_zero: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_primary.rd && x_periph) |=> o_primary_rdata[31:16] == 16'h0000)
		else $error("peripheral read upper half not zero");
	a_periph_wr_fwd: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_primary.wr && x_periph && !x_flashctl)
		|-> (o_peripheral_register_bus.wr && !o_dram_a.wr))
		else $error("peripheral write not forwarded");
	a_dual_read: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_primary.rd && i_secondary_rd && !x_periph && !x_dflash && !y_dflash)
		|-> (o_dram_a.rd && o_dram_b_rd))
		else $error("dual data read not issued");
	a_second_data: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		$past(o_dram_b_rd) |-> o_secondary_read_data == i_dram_b_rdata)
		else $error("secondary read data wrong");
	a_second_flash: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_secondary_rd && y_dflash && !((i_primary.rd || i_primary.wr) && x_dflash))
		|=> o_secondary_read_data == i_dflash_rdata)
		else $error("secondary flash read data wrong");
	a_flash_direct: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_primary.wr && x_dflash) |-> (o_dflash.wr && !o_peripheral_register_bus.wr))
		else $error("flash write went through peripheral bus");
	a_flashctl_local: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_primary.wr && x_flashctl) |-> (!o_peripheral_register_bus.wr && !o_dram_a.wr))
		else $error("flash control write leaked");

	// ==========================================================
	// Read return checks
	a_ram_read_steer: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		o_dram_a.rd |=> o_primary_rdata == i_dram_a_rdata)
		else $error("data RAM read not returned");
	a_flash_read_steer: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_primary.rd && x_dflash) |=> o_primary_rdata == {16'h0000, i_dflash_rdata})
		else $error("flash read not returned");
	a_read_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		!i_primary.rd |=> $stable(o_primary_rdata))
		else $error("primary read data not held");
endmodule : cmf_fabric

/* src/cmf_flash_ctl.sv */
// Flash control decoder: turns peripheral writes into erase requests
`timescale 1ns/1ps
module cmf_flash_ctl (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// Peripheral write into the flash control window
	input wire logic i_sel,
	input wire logic [5:0] i_reg,
	input wire logic [15:0] i_wdata,
	// Erase command to the flash arrays
	output logic o_erase_go,
	output cmf_pkg::cmf_erase_t o_erase
);
	localparam logic [5:0] REG_PAGE = 6'h00;
	localparam logic [5:0] REG_CMD = 6'h01;
	localparam int CMD_ARR_LSB = 1;

	logic [15:0] page_q, page_d;
	logic go_q, go_d;
	cmf_pkg::cmf_erase_t er_q, er_d;

	// Align the page number to the erase granularity of the chosen array
	function automatic logic [23:0] page_base(input cmf_pkg::cmf_array_t arr,
		input logic [15:0] pg);
		if (arr == cmf_pkg::ARR_PROG)
			page_base = 24'(pg) * 24'(cmf_pkg::PFLASH_PAGE_WORDS);
		else
			page_base = 24'(pg) * 24'(cmf_pkg::BDFLASH_PAGE_WORDS);
	endfunction : page_base

	always_comb begin
		page_d = page_q;
		go_d = 1'b0;
		er_d = er_q;
		if (i_sel && i_reg == REG_PAGE) begin
			page_d = i_wdata;
		end
		if (i_sel && i_reg == REG_CMD) begin
			go_d = 1'b1;
			er_d.bulk = i_wdata[0];
			er_d.arr = cmf_pkg::cmf_array_t'(i_wdata[CMD_ARR_LSB +: 2]);
			er_d.page_base = page_base(er_d.arr, page_q);
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			page_q <= 16'h0000;
			go_q <= 1'b0;
			er_q <= '0;
		end else begin
			page_q <= page_d;
			go_q <= go_d;
			er_q <= er_d;
		end
	end

	assign o_erase_go = go_q;
	assign o_erase = er_q;

	a_erase_pulse: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_sel && i_reg == REG_CMD) |=> o_erase_go)
		else $error("erase command not issued");
	a_prog_page_align: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(o_erase_go && o_erase.arr == cmf_pkg::ARR_PROG)
		|-> o_erase.page_base % cmf_pkg::PFLASH_PAGE_WORDS == 0)
		else $error("program flash page not 1KB aligned");
	a_data_page_align: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(o_erase_go && o_erase.arr != cmf_pkg::ARR_PROG)
		|-> o_erase.page_base % cmf_pkg::BDFLASH_PAGE_WORDS == 0)
		else $error("boot or data flash page not 512-byte aligned");
endmodule : cmf_flash_ctl

/* src/cmf_pkg.sv */
// Package for the core memory bus fabric: constants, access kinds, bus carriers
//
// Behaviour
// - Program fetches use a 21-bit address and return one 16-bit word.
// - Program memory writes take only bits 15:0 of the core write bus.
// - Peripheral registers are decoded from the primary data address bus.
// - Byte accesses force the top address bit to zero.
// - Secondary path carries word reads only, 24-bit address, 16-bit data.
// - Peripheral bus runs at data memory rate, no wait states.
// - Primary data RAM port is 32 bits; all other data ports 16 bits.
// - Two data operands read from data RAM in one cycle, one per path.
// - Flash control via peripheral bus; flash array reads/writes go direct.
// - Program flash erases 1KB pages, boot/data flash 512-byte pages, bulk too.
package cmf_pkg;
	// ==========================================================
	// Widths
	localparam int PAB_W = 21;
	localparam int XAB_W = 24;
	localparam int WORD_W = 16;
	localparam int LONG_W = 32;
	localparam int MSB = XAB_W - 1;

	// ==========================================================
	// Address map (word addresses), regions are plain parameters of this fabric
	localparam logic [XAB_W-1:0] PERIPH_BASE = 24'h00f000;
	localparam logic [XAB_W-1:0] PERIPH_MASK = 24'hfff000;
	localparam logic [XAB_W-1:0] DFLASH_BASE = 24'h004000;
	localparam logic [XAB_W-1:0] DFLASH_MASK = 24'hfff000;
	localparam logic [XAB_W-1:0] FLASHCTL_BASE = 24'h00f400;
	localparam logic [XAB_W-1:0] FLASHCTL_MASK = 24'hffffc0;
	localparam logic [PAB_W-1:0] PRAM_BASE = 21'h00f800;
	localparam logic [PAB_W-1:0] PRAM_MASK = 21'h1ff800;

	// ==========================================================
	// Flash erase geometry in bytes
	localparam int PFLASH_PAGE_BYTES = 1024;
	localparam int BDFLASH_PAGE_BYTES = 512;
	localparam int PFLASH_PAGE_WORDS = PFLASH_PAGE_BYTES / 2;
	localparam int BDFLASH_PAGE_WORDS = BDFLASH_PAGE_BYTES / 2;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		SZ_BYTE = 2'h0,
		SZ_WORD = 2'h1,
		SZ_LONG = 2'h2
	} cmf_size_t;

	typedef enum logic [1:0] {
		ARR_PROG = 2'h0,
		ARR_DATA = 2'h1,
		ARR_BOOT = 2'h2
	} cmf_array_t;

	typedef struct packed {
		logic rd;
		logic wr;
		cmf_size_t size;
		logic [XAB_W-1:0] addr;
		logic [LONG_W-1:0] wdata;
	} cmf_xreq_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [XAB_W-1:0] addr;
		logic [WORD_W-1:0] wdata;
	} cmf_wreq_t;

	typedef struct packed {
		logic bulk;
		cmf_array_t arr;
		logic [XAB_W-1:0] page_base;
	} cmf_erase_t;
endpackage : cmf_pkg
